/* File: cifma_core.sv */
// CPU interrupt core: level flags, level mask, global mask, acknowledge, return stack.
// Assumes a CPU sequencer that polls ack each instruction boundary.
`timescale 1ns/1ps
module cifma_core
  import cifma_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Data-memory register port
  input  wire cifma_bus_t       bus,
  output logic           [15:0] rdata,
  // External pins
  input  wire logic       [2:0] ext_pin_in,
  output logic            [2:0] ext_pin_out,
  output logic            [2:0] ext_pin_oe,
  input  wire logic             nmi_pin_in,
  input  wire logic             power_drive_fault,
  output logic                  drive_outputs_hiz,
  // Peripheral requests with their own mask bits, per level
  input  wire logic       [5:0] periph_flag,
  input  wire logic       [5:0] periph_mask,
  // Sequencer
  input  wire logic             reset_pin_event,
  input  wire logic             nmi_instr,
  input  wire logic             swi_instr,
  input  wire logic       [2:0] swi_level,
  input  wire logic             trap_instr,
  input  wire logic             set_global_mask,
  input  wire logic             clear_global_mask,
  input  wire logic             return_instr,
  input  wire logic      [15:0] next_pc,
  output cifma_ack_t            ack,
  output logic           [15:0] return_pc,
  output logic                  global_mask_bit,
  output logic                  stack_overflow
);

  logic [5:0]  level_pending_flags_q;
  logic [5:0]  level_mask_register_q;
  logic        global_mask_q;
  logic        hold_off_q;
  logic        pdp_sync1_q;
  logic        pdp_sync2_q;
  logic        pdp_prev_q;
  logic        hiz_q;
  logic [15:0] stack_q [CIFMA_STACK_DEPTH];
  logic [3:0]  sp_q;
  cifma_ack_t  ack_q;
  logic [15:0] rdata_q;
  logic        ovf_q;

  wire [15:0] cr_rd [4];
  wire [3:0]  edge_p;
  wire [3:0]  en;
  wire [3:0]  lowp;
  wire [3:0]  cr_wr;

  function automatic logic [2:0] first_level(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = CIFMA_NUM_LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] onehot(input logic [2:0] l);
    return 6'h01 << l;
  endfunction

  assign cr_wr[0] = bus.wr & (bus.addr == CIFMA_EXT_A_CR_ADDR);
  assign cr_wr[1] = bus.wr & (bus.addr == CIFMA_EXT_B_CR_ADDR);
  assign cr_wr[2] = bus.wr & (bus.addr == CIFMA_EXT_C_CR_ADDR);
  assign cr_wr[3] = bus.wr & (bus.addr == CIFMA_NMI_CR_ADDR);

  // Nonmaskable pin rides as the fourth lane so no lane indexes past the pin bus
  wire [3:0] pin_all = {nmi_pin_in, ext_pin_in};

  for (genvar g = 0; g < 4; g++) begin : g_pin
    cifma_ext_pin #(.IS_NMI(g == 3)) u_pin (
      .clock       (clock),
      .reset       (reset),
      .pin_in      (pin_all[g]),
      .pin_out     (),
      .pin_oe      (),
      .sel_wr      (cr_wr[g]),
      .wdata       (bus.wdata),
      .cr_rdata    (cr_rd[g]),
      .edge_pulse  (edge_p[g]),
      .req_enabled (en[g]),
      .req_low_pri (lowp[g])
    );
  end

  // Pin A has no data direction; B and C may drive as general-purpose outputs
  assign ext_pin_out = {cr_rd[2][CIFMA_CR_DOUT_BIT], cr_rd[1][CIFMA_CR_DOUT_BIT], 1'b0};
  assign ext_pin_oe  = {cr_rd[2][CIFMA_CR_DIR_BIT] & ~en[2], cr_rd[1][CIFMA_CR_DIR_BIT] & ~en[1], 1'b0};

  wire [5:0] ext_req;
  assign ext_req[CIFMA_LVL_HIGH_IDX] = |(edge_p[2:0] & ~lowp[2:0]);
  assign ext_req[CIFMA_LVL_LOW_IDX]  = |(edge_p[2:0] & lowp[2:0]);
  assign ext_req[4:2]                = 3'h0;
  assign ext_req[CIFMA_LVL_PDP_IDX]  = pdp_sync2_q & ~pdp_prev_q;

  wire [5:0] set_req   = (periph_flag & periph_mask) | ext_req;
  wire       pend_wr   = bus.wr & (bus.addr == CIFMA_LVL_PEND_ADDR);
  wire       mask_wr   = bus.wr & (bus.addr == CIFMA_LVL_MASK_ADDR);
  wire [5:0] sw_clear  = pend_wr ? bus.wdata[5:0] : 6'h00;
  wire [5:0] ready_lvl = level_pending_flags_q & level_mask_register_q;
  wire       nm_take   = reset_pin_event | edge_p[3] | nmi_instr | swi_instr | trap_instr;
  wire       m_take    = ~nm_take & (|ready_lvl) & ~global_mask_q & ~hold_off_q;
  wire [2:0] m_level   = first_level(ready_lvl);
  wire [5:0] ack_clear = m_take ? onehot(m_level) : 6'h00;
  // Trap alone leaves the global mask; any other source in the same cycle still sets it
  wire       gm_set    = m_take | reset_pin_event | edge_p[3] | nmi_instr | swi_instr
                         | set_global_mask;
  wire       any_take  = m_take | nm_take;
  // Full stack: the newest return address overwrites the top entry
  wire [2:0] push_idx  = sp_q[3] ? 3'h7 : sp_q[2:0];
  wire [2:0] nm_code   = reset_pin_event ? CIFMA_NM_RESET_PIN : edge_p[3] ? CIFMA_NM_NMI_PIN :
                         nmi_instr ? CIFMA_NM_NMI_INSTR : swi_instr ? CIFMA_NM_SWI_INSTR : CIFMA_NM_TRAP;

  // Pending flags: hardware set beats software and acknowledge clears
  always_ff @(posedge clock) begin
    if (reset) begin
      level_pending_flags_q <= CIFMA_PEND_RESET;
    end else begin
      level_pending_flags_q <= set_req | (level_pending_flags_q & ~sw_clear & ~ack_clear);
    end
  end

  // No reset term: the mask survives reset
  always_ff @(posedge clock) begin
    if (mask_wr) begin
      level_mask_register_q <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      global_mask_q <= 1'b1;
      hold_off_q    <= 1'b0;
    end else begin
      global_mask_q <= gm_set ? 1'b1 : (clear_global_mask ? 1'b0 : global_mask_q);
      hold_off_q    <= clear_global_mask;
    end
  end

  // Drive protect: synchronise fault, latch output float until software clears the level one flag
  always_ff @(posedge clock) begin
    if (reset) begin
      pdp_sync1_q <= 1'b0;
      pdp_sync2_q <= 1'b0;
      pdp_prev_q  <= 1'b0;
      hiz_q       <= 1'b0;
    end else begin
      pdp_sync1_q <= power_drive_fault;
      pdp_sync2_q <= pdp_sync1_q;
      pdp_prev_q  <= pdp_sync2_q;
      hiz_q       <= pdp_sync2_q | (hiz_q & ~sw_clear[CIFMA_LVL_PDP_IDX]);
    end
  end

  // Return stack
  always_ff @(posedge clock) begin
    if (reset) begin
      sp_q  <= 4'h0;
      ovf_q <= 1'b0;
      for (int i = 0; i < CIFMA_STACK_DEPTH; i++) begin
        stack_q[i] <= CIFMA_PC_RESET;
      end
    end else if (any_take) begin
      stack_q[push_idx] <= next_pc;
      if (sp_q != 4'(CIFMA_STACK_DEPTH)) begin
        sp_q <= sp_q + 4'h1;
      end else begin
        ovf_q <= 1'b1;
      end
    end else if (return_instr && sp_q != 4'h0) begin
      sp_q <= sp_q - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_q <= '0;
    end else begin
      ack_q.valid   <= any_take;
      ack_q.nonmask <= nm_take;
      ack_q.level   <= nm_take ? nm_code : m_level;
      ack_q.ret_pc  <= next_pc;
    end
  end

  wire [15:0] rd_mux =
    (bus.addr == CIFMA_LVL_PEND_ADDR) ? {10'h000, level_pending_flags_q} :
    (bus.addr == CIFMA_LVL_MASK_ADDR) ? {10'h000, level_mask_register_q} :
    (bus.addr == CIFMA_EXT_A_CR_ADDR) ? cr_rd[0] :
    (bus.addr == CIFMA_EXT_B_CR_ADDR) ? cr_rd[1] :
    (bus.addr == CIFMA_EXT_C_CR_ADDR) ? cr_rd[2] :
    (bus.addr == CIFMA_NMI_CR_ADDR)   ? {cr_rd[3][15:7], cr_rd[3][6], 3'h0, cr_rd[3][2], 2'h0} : 16'h0000;

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (bus.rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign rdata             = rdata_q;
  assign ack               = ack_q;
  assign return_pc         = (sp_q == 4'h0) ? CIFMA_PC_RESET : stack_q[3'(sp_q - 4'h1)];
  assign global_mask_bit   = global_mask_q;
  assign drive_outputs_hiz = hiz_q;
  assign stack_overflow    = ovf_q;

  ack_masked_a: assert property (@(posedge clock) disable iff (reset)
    m_take |-> (~global_mask_q && level_mask_register_q[m_level])) else $error("masked level taken");
  ack_clears_a: assert property (@(posedge clock) disable iff (reset)
    (m_take && !set_req[m_level]) |=> !level_pending_flags_q[$past(m_level)]) else $error("flag kept");
  ack_gmask_a: assert property (@(posedge clock) disable iff (reset)
    (m_take || nmi_instr || swi_instr) |=> global_mask_q) else $error("global mask not set");
  trap_keep_a: assert property (@(posedge clock) disable iff (reset)
    (trap_instr && !reset_pin_event && !edge_p[3] && !nmi_instr && !swi_instr && !set_global_mask
     && !clear_global_mask) |=> global_mask_q == $past(global_mask_q)) else $error("trap changed mask");
  nm_ack_a: assert property (@(posedge clock) disable iff (reset)
    nm_take |=> (ack.valid && ack.nonmask)) else $error("nonmaskable not acked");
  pend_set_a: assert property (@(posedge clock) disable iff (reset)
    set_req[0] |=> level_pending_flags_q[0]) else $error("set lost");
  w1c_a: assert property (@(posedge clock) disable iff (reset)
    (sw_clear[2] && !set_req[2]) |=> !level_pending_flags_q[2]) else $error("w1c failed");
  swi_keep_a: assert property (@(posedge clock) disable iff (reset)
    (swi_instr && level_pending_flags_q[swi_level] && !sw_clear[swi_level])
    |=> level_pending_flags_q[$past(swi_level)]) else $error("swi cleared flag");
  holdoff_a: assert property (@(posedge clock) disable iff (reset)
    clear_global_mask |=> !m_take) else $error("taken in hold-off");
  prio_a: assert property (@(posedge clock) disable iff (reset)
    m_take |-> (ready_lvl[m_level] && (ready_lvl & ((6'h01 << m_level) - 6'h01)) == 6'h00))
    else $error("priority wrong");
  push_a: assert property (@(posedge clock) disable iff (reset)
    (any_take && sp_q < 4'h8) |=> sp_q == $past(sp_q) + 4'h1) else $error("no push");

endmodule

/* File: cifma_core_bench.sv */
// Self-checking bench for the interrupt flag, mask and acknowledge core.
// Assumes the core and the sequencer stand-in on one 100 MHz clock.
`timescale 1ns/1ps
module cifma_core_bench;
  import cifma_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  cifma_bus_t  bus = '0;
  logic [15:0] rdata, return_pc, next_pc;
  logic [2:0]  ext_pin_in = 3'h0;
  logic [2:0]  ext_pin_out, ext_pin_oe;
  logic        nmi_pin_in = 1'b1;
  logic        power_drive_fault = 1'b0;
  logic [5:0]  periph_flag = 6'h00;
  logic [5:0]  periph_mask = 6'h00;
  logic        reset_pin_event = 1'b0, nmi_instr = 1'b0, swi_instr = 1'b0;
  logic        trap_instr = 1'b0, set_global_mask = 1'b0, clear_global_mask = 1'b0;
  logic        ret_req = 1'b0;
  logic [2:0]  swi_level = 3'h3;
  logic        return_instr, global_mask_bit, stack_overflow, drive_outputs_hiz;
  cifma_ack_t  ack, a;
  logic [15:0] old;
  int          n_fail = 0, checked = 0, cycles = 0;

  cifma_core u_cifma_core (.clock(clock), .reset(reset), .bus(bus), .rdata(rdata),
    .ext_pin_in(ext_pin_in), .ext_pin_out(ext_pin_out), .ext_pin_oe(ext_pin_oe),
    .nmi_pin_in(nmi_pin_in), .power_drive_fault(power_drive_fault),
    .drive_outputs_hiz(drive_outputs_hiz), .periph_flag(periph_flag), .periph_mask(periph_mask),
    .reset_pin_event(reset_pin_event), .nmi_instr(nmi_instr), .swi_instr(swi_instr),
    .swi_level(swi_level), .trap_instr(trap_instr), .set_global_mask(set_global_mask),
    .clear_global_mask(clear_global_mask), .return_instr(return_instr), .next_pc(next_pc),
    .ack(ack), .return_pc(return_pc), .global_mask_bit(global_mask_bit),
    .stack_overflow(stack_overflow));
  cifma_seq_model u_cifma_seq_model (.clock(clock), .reset(reset), .ack(ack),
    .next_pc(next_pc), .return_instr(return_instr), .ret_req(ret_req));

  always #5 clock = ~clock;

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [15:0] ad, logic [15:0] d);
    bus.wr = 1'b1;
    bus.addr = ad;
    bus.wdata = d;
    tick();
    bus.wr = 1'b0;
    tick();
  endtask
  task automatic rdchk(logic [15:0] ad, logic [15:0] exp);
    bus.rd = 1'b1;
    bus.addr = ad;
    tick();
    bus.rd = 1'b0;
    tick();
    chk(rdata, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic req(logic [5:0] f, logic [5:0] m);
    periph_mask = m;
    periph_flag = f;
    tick();
    periph_flag = 6'h00;
    tick();
  endtask
  // Catches the one-cycle acknowledge whichever edge it lands on
  task automatic wait_ack(int n);
    a = '0;
    repeat (n) begin
      if (a.valid !== 1'b1) begin
        a = ack;
        if (a.valid !== 1'b1) tick();
      end
    end
  endtask

  task automatic t_reset_keep();
    wr(CIFMA_LVL_MASK_ADDR, 16'h002A);
    req(6'h01, 6'h01);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick();
    rdchk(CIFMA_LVL_MASK_ADDR, 16'h002A);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0000);
    chk(16'(global_mask_bit), 16'h0001);
  endtask
  task automatic t_regs();
    wr(CIFMA_LVL_MASK_ADDR, 16'hFFFF);
    rdchk(CIFMA_LVL_MASK_ADDR, 16'h003F);
    rdchk(16'h0010, 16'h0000);
  endtask
  task automatic t_pending();
    req(6'h24, 6'h04);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0004);
    req(6'h20, 6'h20);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0024);
    wr(CIFMA_LVL_PEND_ADDR, 16'h0000);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0024);
    wr(CIFMA_LVL_PEND_ADDR, 16'h0024);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0000);
  endtask
  task automatic t_pins();
    wr(CIFMA_EXT_A_CR_ADDR, 16'h0005);
    ext_pin_in[0] = 1'b1;
    tick(6);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0001);
    rdchk(CIFMA_EXT_A_CR_ADDR, 16'h8045);
    wr(CIFMA_EXT_B_CR_ADDR, 16'h0007);
    ext_pin_in[1] = 1'b1;
    tick(6);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0021);
    wr(CIFMA_EXT_C_CR_ADDR, 16'h0018);
    chk(16'({ext_pin_oe, ext_pin_out}), 16'h0024);
    power_drive_fault = 1'b1;
    tick(6);
    chk(16'(drive_outputs_hiz), 16'h0001);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0023);
    power_drive_fault = 1'b0;
    tick(4);
    wr(CIFMA_LVL_PEND_ADDR, 16'h0023);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0000);
    chk(16'(drive_outputs_hiz), 16'h0000);
  endtask
  task automatic t_ack();
    wr(CIFMA_LVL_MASK_ADDR, 16'h003B);
    req(6'h04, 6'h04);
    pulse(clear_global_mask);
    wait_ack(8);
    chk(16'(a.valid), 16'h0000);
    wr(CIFMA_LVL_MASK_ADDR, 16'h003F);
    wait_ack(4);
    chk(16'({a.valid, a.nonmask, a.level}), 16'h0012);
    chk(16'(global_mask_bit), 16'h0001);
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0000);
    pulse(ret_req);
  endtask
  task automatic t_prio();
    pulse(trap_instr);
    wait_ack(4);
    old = return_pc;
    req(6'h14, 6'h14);
    pulse(clear_global_mask);
    chk(16'(ack.valid), 16'h0000);
    tick();
    chk(16'(ack.valid), 16'h0000);
    wait_ack(4);
    chk(16'({a.valid, a.level}), 16'h000A);
    chk(return_pc, a.ret_pc);
    pulse(ret_req);
    chk(return_pc, old);
    pulse(clear_global_mask);
    wait_ack(6);
    chk(16'({a.valid, a.level}), 16'h000C);
    pulse(ret_req);
    tick();
    pulse(ret_req);
  endtask
  task automatic t_nonmask();
    wr(CIFMA_LVL_MASK_ADDR, 16'h0000);
    req(6'h08, 6'h08);
    for (int i = 0; i < 5; i++) begin
      pulse(clear_global_mask);
      case (i)
        0: pulse(reset_pin_event);
        1: nmi_pin_in = 1'b0;
        2: pulse(nmi_instr);
        3: pulse(swi_instr);
        default: pulse(trap_instr);
      endcase
      wait_ack(10);
      chk(16'({a.valid, a.nonmask, a.level}), 16'h0018 + 16'(i));
      chk(16'(global_mask_bit), (i == 4) ? 16'h0000 : 16'h0001);
      pulse(ret_req);
    end
    rdchk(CIFMA_LVL_PEND_ADDR, 16'h0008);
  endtask
  task automatic t_stack();
    for (int i = 0; i < 9; i++) begin
      pulse(trap_instr);
      wait_ack(4);
      if (i == 7) chk(16'(stack_overflow), 16'h0000);
    end
    chk(16'(stack_overflow), 16'h0001);
  endtask

  initial begin
    tick(16);
    reset = 1'b0;
    tick();
    t_reset_keep();
    t_regs();
    t_pending();
    t_pins();
    t_ack();
    t_prio();
    t_nonmask();
    t_stack();
    report_and_stop();
  end
endmodule

/* File: cifma_ext_pin.sv */
// One external interrupt pin: synchroniser, edge detect, control register.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
module cifma_ext_pin
  import cifma_pkg::*;
#(
  parameter logic IS_NMI = 1'b0
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Pin
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  // Register access, selected by parent
  input  wire logic        sel_wr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] cr_rdata,
  // Request out
  output logic             edge_pulse,
  output logic             req_enabled,
  output logic             req_low_pri
);

  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic       flag_q;
  logic [4:0] cr_q;
  wire        edge_seen;
  wire        flag_clr;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign edge_seen = cr_q[CIFMA_CR_POL_BIT] ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
  assign flag_clr  = sel_wr & wdata[CIFMA_CR_FLAG_BIT];

  // Flag sets on the edge whether or not enabled; set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      flag_q <= 1'b0;
      cr_q   <= CIFMA_CR_RESET;
    end else begin
      flag_q <= edge_seen | (flag_q & ~flag_clr);
      if (sel_wr) begin
        cr_q <= {wdata[CIFMA_CR_DIR_BIT], wdata[CIFMA_CR_DOUT_BIT], wdata[CIFMA_CR_POL_BIT],
                 wdata[CIFMA_CR_PRI_BIT], wdata[CIFMA_CR_EN_BIT]};
      end
    end
  end

  assign req_enabled = IS_NMI | cr_q[CIFMA_CR_EN_BIT];
  assign req_low_pri = cr_q[CIFMA_CR_PRI_BIT];
  assign edge_pulse  = edge_seen & req_enabled;
  assign pin_out     = IS_NMI ? 1'b0 : cr_q[3];
  assign pin_oe      = IS_NMI ? 1'b0 : (cr_q[4] & ~cr_q[CIFMA_CR_EN_BIT]);
  assign cr_rdata    = {flag_q, 8'h00, sync2_q, 1'b0, cr_q[4], cr_q[3], cr_q[2], cr_q[1], cr_q[0]};

endmodule

/* File: cifma_pkg.sv */
// Package for the CPU interrupt flag, mask and acknowledge block.
// Assumes a 16-bit data-memory register port on the CPU clock.
package cifma_pkg;

  localparam logic [15:0] CIFMA_LVL_MASK_ADDR  = 16'h0004;
  localparam logic [15:0] CIFMA_LVL_PEND_ADDR  = 16'h0006;
  localparam logic [15:0] CIFMA_EXT_A_CR_ADDR  = 16'h7070;
  localparam logic [15:0] CIFMA_NMI_CR_ADDR    = 16'h7072;
  localparam logic [15:0] CIFMA_EXT_B_CR_ADDR  = 16'h7078;
  localparam logic [15:0] CIFMA_EXT_C_CR_ADDR  = 16'h707A;

  localparam int CIFMA_NUM_LEVELS   = 6;
  localparam int CIFMA_STACK_DEPTH  = 8;
  localparam int CIFMA_LVL_HIGH_IDX = 0;
  localparam int CIFMA_LVL_PDP_IDX  = 1;
  localparam int CIFMA_LVL_LOW_IDX  = 5;

  // Control register field positions
  localparam int CIFMA_CR_FLAG_BIT = 15;
  localparam int CIFMA_CR_PIN_BIT  = 6;
  localparam int CIFMA_CR_DIR_BIT  = 4;
  localparam int CIFMA_CR_DOUT_BIT = 3;
  localparam int CIFMA_CR_POL_BIT  = 2;
  localparam int CIFMA_CR_PRI_BIT  = 1;
  localparam int CIFMA_CR_EN_BIT   = 0;

  localparam logic [5:0]  CIFMA_PEND_RESET = 6'h00;
  localparam logic [4:0]  CIFMA_CR_RESET   = 5'h00;
  localparam logic [15:0] CIFMA_PC_RESET   = 16'h0000;

  // Nonmaskable sources
  typedef enum logic [2:0] {
    CIFMA_NM_RESET_PIN = 3'h0,
    CIFMA_NM_NMI_PIN   = 3'h1,
    CIFMA_NM_NMI_INSTR = 3'h2,
    CIFMA_NM_SWI_INSTR = 3'h3,
    CIFMA_NM_TRAP      = 3'h4
  } cifma_nm_src_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cifma_bus_t;

  typedef struct packed {
    logic        valid;
    logic        nonmask;
    logic [2:0]  level;
    logic [15:0] ret_pc;
  } cifma_ack_t;

endpackage

/* File: cifma_seq_model.sv */
// Sequencer stand-in: running program counter and return requests.
// Assumes the bench asks for each return with a one-cycle ret_req.
`timescale 1ns/1ps
module cifma_seq_model
  import cifma_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Core side
  input  wire cifma_ack_t  ack,
  output logic      [15:0] next_pc,
  output logic             return_instr,
  // Bench side
  input  wire logic        ret_req
);
  logic [15:0] pc_q;

  // A fresh address every cycle makes each pushed entry distinct
  assign next_pc      = pc_q + 16'h0001;
  assign return_instr = ret_req;

  always_ff @(posedge clock) begin
    if (reset) begin
      pc_q <= 16'h0100;
    end else begin
      pc_q <= pc_q + 16'h0001;
    end
  end
endmodule
